// >>> verilog/status_readback_pkg.sv
// constants for the decoder status readback register bank
//
// Function
// R1 - 0x43 bits 7, 5, 3 flag overflow of luma/green, blue-diff, red-diff; bits 1-0 reserved.
// R2 - Register 0x43 shows underflow of the same three channels in bits 6, 4 and 2.
// R3 - Bit 7 of register 0x44 is high while burst is seen and low for a monochrome input.
// R4 - 0x44 bits 6-0 hold the top seven subcarrier phase error bits, refreshed each line.
// R5 - Register 0x45 returns the 8-bit decoder reference value.
// R6 - Register 0x46 is read-only and returns a fixed part family code.
// R7 - Register 0x47 returns the silicon revision number.
// R8 - 0x4B bits 6-5 give the comb in use: 00 three-tap, 01 lower, 10 upper, 11 two-tap.
// R9 - Bit 7 of register 0x4B is set when chroma phase is killed by a comb failure.
// R10 - Bits 4-0 of register 0x4B show the adaptive lookup table output.
// R11 - Addresses 0x48-0x4A and 0x4C-0xFF are reserved read-only locations; the code places irq status and mask at 0x50 and 0x51.
// R12 - The datapath separates luma and chroma, demodulates chroma, then scales or makes RGB.
// R13 - Writes to the status range are ignored and change no reported value.
// R14 - Each status field is captured as a whole so one read returns a consistent snapshot.
package status_readback_pkg;

    localparam logic [7:0]  ADDR_RANGE_FLAGS   = 8'h43;
    localparam logic [7:0]  ADDR_BURST_PHASE   = 8'h44;
    localparam logic [7:0]  ADDR_REFERENCE     = 8'h45;
    localparam logic [7:0]  ADDR_PART_FAMILY   = 8'h46;
    localparam logic [7:0]  ADDR_REVISION      = 8'h47;
    localparam logic [7:0]  ADDR_RSVD_LOW      = 8'h48;
    localparam logic [7:0]  ADDR_COMB_STATE    = 8'h4b;
    localparam logic [7:0]  ADDR_RSVD_HIGH     = 8'h4c;
    localparam logic [7:0]  ADDR_IRQ_STATUS    = 8'h50;
    localparam logic [7:0]  ADDR_IRQ_MASK      = 8'h51;

    localparam int          BIT_LUMA_OVER      = 7;
    localparam int          BIT_LUMA_UNDER     = 6;
    localparam int          BIT_BLUE_OVER      = 5;
    localparam int          BIT_BLUE_UNDER     = 4;
    localparam int          BIT_RED_OVER       = 3;
    localparam int          BIT_RED_UNDER      = 2;
    localparam int          BIT_COLOUR_KILL    = 7;
    localparam int          BIT_PHASE_KILL     = 7;

    // arbitrary neutral identity values
    localparam logic [7:0]  PART_FAMILY_VALUE  = 8'h5a;
    localparam logic [7:0]  REVISION_VALUE     = 8'h01;

    localparam logic [7:0]  RESERVED_VALUE     = 8'h00;
    localparam logic [7:0]  STATUS_RESET       = 8'h00;
    localparam logic [7:0]  MASK_RESET         = 8'h00;

    localparam logic [1:0]  COMB_THREE_TAP     = 2'h0;
    localparam logic [1:0]  COMB_THREE_LOWER   = 2'h1;
    localparam logic [1:0]  COMB_THREE_UPPER   = 2'h2;
    localparam logic [1:0]  COMB_TWO_TAP       = 2'h3;

    // irq status bits: 0 range flag set while none was held, 1 colour kill change,
    // 2 phase kill rise, 3 comb change
    localparam int          IRQ_RANGE          = 0;
    localparam int          IRQ_KILL           = 1;
    localparam int          IRQ_COMB_FAIL_PHASE_KILL          = 2;
    localparam int          IRQ_COMB           = 3;

endpackage : status_readback_pkg

// >>> verilog/decoder_status_readback.sv
// decoder status readback bank with wishbone slave and interrupt
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps

module decoder_status_readback
    import status_readback_pkg::*;
(
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    input  wire logic        clk_en_i,
    // wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [0:0]  wb_sel_i,
    input  wire logic [7:0]  wb_dat_i,
    output logic      [7:0]  wb_dat_o,
    output logic             wb_ack_o,
    // pipeline status, pixel clock domain
    input  wire logic        luma_green_over_i,
    input  wire logic        luma_green_under_i,
    input  wire logic        blue_diff_over_i,
    input  wire logic        blue_diff_under_i,
    input  wire logic        red_diff_over_i,
    input  wire logic        red_diff_under_i,
    input  wire logic        colour_kill_flag_i,
    input  wire logic [6:0]  subcarrier_phase_error_i,
    input  wire logic        line_end_i,
    input  wire logic [7:0]  decoder_reference_value_i,
    input  wire logic        comb_fail_phase_kill_i,
    input  wire logic [1:0]  comb_filter_state_i,
    input  wire logic [4:0]  adaptive_table_output_i,
    output logic             irq_o
);

    ////////////////////////////////////////////////////////////////////////////
    // two-stage input synchronisers
    localparam int SYNC_W = 6 + 1 + 7 + 1 + 8 + 1 + 2 + 5;

    logic [SYNC_W-1:0] raw_in;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;

    assign raw_in = {luma_green_over_i, luma_green_under_i, blue_diff_over_i,
                     blue_diff_under_i, red_diff_over_i, red_diff_under_i,
                     colour_kill_flag_i, subcarrier_phase_error_i, line_end_i,
                     decoder_reference_value_i, comb_fail_phase_kill_i,
                     comb_filter_state_i, adaptive_table_output_i}; // R12

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else if (clk_en_i) begin
            sync1_reg <= raw_in;
            sync2_reg <= sync1_reg;
        end
    end

    logic [5:0] s_range;
    logic       s_kill;
    logic [6:0] s_phase;
    logic       s_line;
    logic [7:0] s_ref;
    logic       s_comb_fail_phase_kill;
    logic [1:0] s_comb;
    logic [4:0] s_table;

    assign {s_range, s_kill, s_phase, s_line, s_ref, s_comb_fail_phase_kill, s_comb, s_table} = sync2_reg;

    ////////////////////////////////////////////////////////////////////////////
    // status snapshot registers
    logic [7:0] range_flags_reg;
    logic [7:0] burst_phase_reg;
    logic [7:0] reference_reg;
    logic [7:0] comb_state_reg;
    logic       line_seen_reg;
    logic       line_edge;

    assign line_edge = s_line & ~line_seen_reg;

    // a word changing across the crossing may tear; reference and comb
    // state values are taken only when two successive samples agree
    logic [SYNC_W-1:0] prev_reg;
    logic              stable;

    assign stable = (prev_reg == sync2_reg);

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            prev_reg      <= '0;
            line_seen_reg <= 1'h0;
        end else if (clk_en_i) begin
            prev_reg      <= sync2_reg;
            line_seen_reg <= s_line;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            range_flags_reg <= STATUS_RESET;
        end else if (clk_en_i) begin
            range_flags_reg[BIT_LUMA_OVER]  <= s_range[5]; // R1
            range_flags_reg[BIT_LUMA_UNDER] <= s_range[4]; // R2
            range_flags_reg[BIT_BLUE_OVER]  <= s_range[3]; // R1
            range_flags_reg[BIT_BLUE_UNDER] <= s_range[2]; // R2
            range_flags_reg[BIT_RED_OVER]   <= s_range[1]; // R1
            range_flags_reg[BIT_RED_UNDER]  <= s_range[0]; // R2
            range_flags_reg[1:0]            <= 2'h0; // R1
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            burst_phase_reg <= STATUS_RESET;
        end else if (clk_en_i) begin
            burst_phase_reg[BIT_COLOUR_KILL] <= s_kill; // R3
            if (line_edge) begin
                burst_phase_reg[6:0] <= s_phase; // R4 R14
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            reference_reg <= STATUS_RESET;
        end else if (clk_en_i && stable) begin
            reference_reg <= s_ref; // R5 R14
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            comb_state_reg <= STATUS_RESET;
        end else if (clk_en_i && stable) begin
            comb_state_reg <= {s_comb_fail_phase_kill, s_comb, s_table}; // R8 R9 R10 R14
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt events
    logic [3:0] irq_status_reg;
    logic [3:0] irq_mask_reg;
    logic [3:0] events;
    logic [3:0] clear_bits;

    assign events[IRQ_RANGE] = |range_flags_reg[7:2] == 1'h0 ? |s_range : 1'h0;
    assign events[IRQ_KILL]  = s_kill != burst_phase_reg[BIT_COLOUR_KILL];
    assign events[IRQ_COMB_FAIL_PHASE_KILL] = stable & s_comb_fail_phase_kill & ~comb_state_reg[BIT_PHASE_KILL];
    assign events[IRQ_COMB]  = stable & (s_comb != comb_state_reg[6:5]);

    ////////////////////////////////////////////////////////////////////////////
    // wishbone slave
    logic bus_req;
    logic wr_hit;

    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_hit  = bus_req & wb_we_i & wb_sel_i[0];

    function automatic logic [7:0] read_mux(input logic [7:0] adr,
                                            input logic [7:0] range_v,
                                            input logic [7:0] burst_v,
                                            input logic [7:0] ref_v,
                                            input logic [7:0] comb_v,
                                            input logic [3:0] sts_v,
                                            input logic [3:0] msk_v);
        logic [7:0] r;
        r = RESERVED_VALUE; // R11
        case (adr)
            ADDR_RANGE_FLAGS: r = range_v;
            ADDR_BURST_PHASE: r = burst_v;
            ADDR_REFERENCE:   r = ref_v;
            ADDR_PART_FAMILY: r = PART_FAMILY_VALUE; // R6
            ADDR_REVISION:    r = REVISION_VALUE; // R7
            ADDR_COMB_STATE:  r = comb_v;
            ADDR_IRQ_STATUS:  r = {4'h0, sts_v};
            ADDR_IRQ_MASK:    r = {4'h0, msk_v};
            default:          r = RESERVED_VALUE; // R11
        endcase
        return r;
    endfunction

    assign clear_bits = (wr_hit && wb_adr_i == ADDR_IRQ_STATUS) ? wb_dat_i[3:0] : 4'h0;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            wb_ack_o <= 1'h0;
            wb_dat_o <= 8'h00;
        end else if (clk_en_i) begin
            wb_ack_o <= bus_req;
            if (bus_req && !wb_we_i) begin
                wb_dat_o <= read_mux(wb_adr_i, range_flags_reg, burst_phase_reg,
                                     reference_reg, comb_state_reg,
                                     irq_status_reg, irq_mask_reg); // R14
            end
        end
    end

    // status addresses other than irq status and irq mask take no write effect
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            irq_mask_reg <= MASK_RESET[3:0];
        end else if (clk_en_i && wr_hit && wb_adr_i == ADDR_IRQ_MASK) begin
            irq_mask_reg <= wb_dat_i[3:0]; // R13
        end
    end

    // set wins over write-one-to-clear
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            irq_status_reg <= STATUS_RESET[3:0];
        end else if (clk_en_i) begin
            irq_status_reg <= (irq_status_reg & ~clear_bits) | events;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            irq_o <= 1'h0;
        end else if (clk_en_i) begin
            irq_o <= |(((irq_status_reg & ~clear_bits) | events) & irq_mask_reg);
        end
    end

endmodule // decoder_status_readback

// >>> tb/decoder_status_readback_properties.sv
// concurrent checks on the status readback bank ports
`timescale 1ns/1ps
module status_readback_checker
    import status_readback_pkg::*;
(
    input wire logic       core_clk_i,
    input wire logic       reset_i,
    input wire logic       clk_en_i,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [0:0] wb_sel_i,
    input wire logic [7:0] wb_dat_i,
    input wire logic [7:0] wb_dat_o,
    input wire logic       wb_ack_o,
    input wire logic [7:0] decoder_reference_value_i,
    input wire logic       comb_fail_phase_kill_i,
    input wire logic [1:0] comb_filter_state_i,
    input wire logic [4:0] adaptive_table_output_i,
    input wire logic       irq_o
);
    ////////////////////////////////////////////////////////////////
    logic       tk;
    logic       rd;
    logic [7:0] comb_v;
    assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en_i;
    assign rd = tk && !wb_we_i;
    assign comb_v = {comb_fail_phase_kill_i, comb_filter_state_i, adaptive_table_output_i};
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    ////////////////////////////////////////////////////////////////
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_next_a: assert property (tk |=> wb_ack_o)
        else $error("request not acked next cycle");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i))
        else $error("ack without request");
    part_code_a: assert property (rd && wb_adr_i == ADDR_PART_FAMILY |=>
        wb_dat_o == PART_FAMILY_VALUE) else $error("part code wrong");
    revision_code_a: assert property (rd && wb_adr_i == ADDR_REVISION |=>
        wb_dat_o == REVISION_VALUE) else $error("revision wrong");
    reserved_zero_a: assert property (rd && (wb_adr_i inside
        {[8'h48:8'h4a], [8'h4c:8'h4f], [8'h52:8'hff]}) |=> wb_dat_o == RESERVED_VALUE)
        else $error("reserved read not zero");
    ref_value_a: assert property (($stable(decoder_reference_value_i)
        && clk_en_i) [*6] ##0 rd && wb_adr_i == ADDR_REFERENCE
        |=> wb_dat_o == $past(decoder_reference_value_i))
        else $error("reference value wrong");
    comb_snapshot_a: assert property (($stable(comb_v) && clk_en_i) [*6] ##0
        rd && wb_adr_i == ADDR_COMB_STATE |=> wb_dat_o == $past(comb_v))
        else $error("comb state wrong");
    mask_off_a: assert property (tk && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_IRQ_MASK
        && wb_dat_i == 8'h00 |-> ##[1:3] !irq_o) else $error("irq high with mask clear");
    cover property (tk && wb_we_i);
    cover property ($rose(irq_o));
    cover property (rd && wb_adr_i == ADDR_COMB_STATE);
    cover property (!clk_en_i ##1 rd);
endmodule // status_readback_checker

bind decoder_status_readback status_readback_checker i_chk (.*);

// >>> tb/tb_decoder_status_readback.sv
// self-checking bench for the decoder status readback bank
`timescale 1ns/1ps
module tb_decoder_status_readback
    import status_readback_pkg::*;
;
    logic       core_clk_i = 1'h0;
    logic       reset_i = 1'h1;
    logic       clk_en_i = 1'h1;
    logic       wb_cyc_i = 1'h0;
    logic       wb_stb_i = 1'h0;
    logic       wb_we_i = 1'h0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [0:0] wb_sel_i = 1'h1;
    logic [7:0] wb_dat_i = 8'h00;
    logic [7:0] wb_dat_o;
    logic       wb_ack_o;
    logic       irq_o;
    logic [5:0] rng = 6'h00;
    logic       colour_kill_flag_i = 1'h0;
    logic [6:0] subcarrier_phase_error_i = 7'h00;
    logic       line_end_i = 1'h0;
    logic [7:0] decoder_reference_value_i = 8'h00;
    logic       comb_fail_phase_kill_i = 1'h0;
    logic [1:0] comb_filter_state_i = 2'h0;
    logic [4:0] adaptive_table_output_i = 5'h00;
    logic [7:0] rsvd [8] = '{8'h48, 8'h49, 8'h4a, 8'h4c, 8'h4f, 8'h52, 8'h80, 8'hff};
    int         fails = 0;
    int         checks = 0;
    ////////////////////////////////////////////////////////////////
    decoder_status_readback i_dut (.*, .luma_green_over_i(rng[5]), .luma_green_under_i(rng[4]),
        .blue_diff_over_i(rng[3]), .blue_diff_under_i(rng[2]), .red_diff_over_i(rng[1]),
        .red_diff_under_i(rng[0]));
    initial forever #2 core_clk_i = ~core_clk_i;
    ////////////////////////////////////////////////////////////////
    task automatic results();
        if (fails == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                       output logic [7:0] q);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge core_clk_i);
        end while (wb_ack_o !== 1'h1);
        q = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        @(posedge core_clk_i);
        cmp("ack drop", 8'h00, {7'h00, wb_ack_o});
    endtask
    task automatic rd(input string what, input logic [7:0] adr, input logic [7:0] exp);
        logic [7:0] q;
        bus(1'b0, adr, 8'h00, q);
        cmp(what, exp, q);
    endtask
    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        logic [7:0] q;
        bus(1'b1, adr, dat, q);
    endtask
    task automatic settle();
        repeat (6) @(posedge core_clk_i);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        int i;
        repeat (20) @(posedge core_clk_i);
        reset_i <= 1'h0;
        @(posedge core_clk_i);
        rd("part", ADDR_PART_FAMILY, PART_FAMILY_VALUE);
        rd("rev", ADDR_REVISION, REVISION_VALUE);
        wr(ADDR_PART_FAMILY, 8'hff);
        wr(ADDR_RSVD_LOW, 8'hff);
        rd("part", ADDR_PART_FAMILY, PART_FAMILY_VALUE);
        for (i = 0; i < 8; i++) rd("rsvd", rsvd[i], RESERVED_VALUE);
        for (i = 0; i < 6; i++) begin
            rng <= 6'h20 >> i;
            settle();
            rd("range", ADDR_RANGE_FLAGS, {6'h20 >> i, 2'h0});
        end
        rng <= 6'h3f;
        settle();
        wr(ADDR_RANGE_FLAGS, 8'h00);
        rd("range", ADDR_RANGE_FLAGS, 8'hfc);
        rng <= 6'h00;
        colour_kill_flag_i <= 1'h1;
        subcarrier_phase_error_i <= 7'h55;
        settle();
        line_end_i <= 1'h1;
        settle();
        subcarrier_phase_error_i <= 7'h2a;
        settle();
        rd("burst", ADDR_BURST_PHASE, 8'hd5);
        rd("range", ADDR_RANGE_FLAGS, 8'h00);
        line_end_i <= 1'h0;
        colour_kill_flag_i <= 1'h0;
        settle();
        rd("burst", ADDR_BURST_PHASE, 8'h55);
        line_end_i <= 1'h1;
        settle();
        rd("burst", ADDR_BURST_PHASE, 8'h2a);
        for (i = 0; i < 4; i++) begin
            decoder_reference_value_i <= 8'ha5 ^ (8'h3c << i);
            comb_filter_state_i <= i[1:0];
            comb_fail_phase_kill_i <= i[0];
            adaptive_table_output_i <= 5'h11 ^ i[4:0];
            settle();
            rd("ref", ADDR_REFERENCE, 8'ha5 ^ (8'h3c << i));
            rd("comb", ADDR_COMB_STATE, {i[0], i[1:0], 5'h11 ^ i[4:0]});
        end
        clk_en_i <= 1'h0;
        decoder_reference_value_i <= 8'h99;
        settle();
        clk_en_i <= 1'h1;
        rd("frozen ref", ADDR_REFERENCE, 8'h45);
        settle();
        rd("ref", ADDR_REFERENCE, 8'h99);
        rd("irq_sts", ADDR_IRQ_STATUS, 8'h0f);
        cmp("irq", 8'h00, {7'h00, irq_o});
        wr(ADDR_IRQ_MASK, 8'h04);
        rd("irq_msk", ADDR_IRQ_MASK, 8'h04);
        cmp("irq", 8'h01, {7'h00, irq_o});
        wr(ADDR_IRQ_STATUS, 8'h04);
        settle();
        rd("irq_sts", ADDR_IRQ_STATUS, 8'h0b);
        cmp("irq", 8'h00, {7'h00, irq_o});
        wb_sel_i <= 1'h0;
        wr(ADDR_IRQ_MASK, 8'h0f);
        wb_sel_i <= 1'h1;
        rd("irq_msk", ADDR_IRQ_MASK, 8'h04);
        wr(ADDR_IRQ_MASK, 8'h00);
        results();
    end
    initial begin
        #20000;
        fails++;
        results();
    end
endmodule // tb_decoder_status_readback
